// [prox_pkg.sv]
// Package for the proximity result and offset register block.
// Assumes a register port driven by the serial interface logic on ref_clk.
package prox_pkg;
  localparam logic [7:0] PROX_LOW_ADDR = 8'h18;
  localparam logic [7:0] PROX_HIGH_ADDR = 8'h19;
  localparam logic [7:0] PROX_OFFSET_ADDR = 8'h1E;
  localparam logic [7:0] PROX_OFFSET_RESET = 8'h00;
  localparam logic [15:0] PROX_RESULT_RESET = 16'h0000;
  localparam int PROX_SIGN_BIT = 7;
  localparam logic [15:0] PROX_RESULT_MAX = 16'hFFFF;
  // Proximity gain multipliers by select code.
  localparam logic [2:0] PROX_GAIN_MULT_0 = 3'h1;
  localparam logic [2:0] PROX_GAIN_MULT_1 = 3'h2;
  localparam logic [2:0] PROX_GAIN_MULT_2 = 3'h4;
  localparam logic [2:0] PROX_GAIN_MULT_3 = 3'h7;
endpackage : prox_pkg

// [prox_offset_calc.sv]
// Offset correction of a raw proximity sample, purely combinational.
// Assumes gain, drive and pulse settings are stable register values.
`timescale 1ns/1ps
`default_nettype none
module prox_offset_calc (
  input wire logic [15:0] raw_result,
  input wire logic [7:0] offset_trim,
  input wire logic [1:0] proximity_gain_select,
  input wire logic [1:0] led_drive_strength,
  input wire logic [7:0] proximity_pulse_count,
  output logic [15:0] corrected_result
);
  logic [2:0] gain_mult;
  logic [2:0] drive_mult;
  logic [23:0] shift_amount;
  logic [24:0] sum_up;
  logic [24:0] diff_down;

  always_comb begin
    unique case (proximity_gain_select)
      2'h0: gain_mult = prox_pkg::PROX_GAIN_MULT_0;
      2'h1: gain_mult = prox_pkg::PROX_GAIN_MULT_1;
      2'h2: gain_mult = prox_pkg::PROX_GAIN_MULT_2;
      2'h3: gain_mult = prox_pkg::PROX_GAIN_MULT_3;
    endcase
    // Stronger drive code means weaker current, so a smaller shift.
    drive_mult = 3'h4 - {1'b0, led_drive_strength};
    // Size of shift scales with gain, drive and pulse count.
    shift_amount = 24'({17'h0, offset_trim[6:0]} * gain_mult * drive_mult
                       * ({1'b0, proximity_pulse_count} + 9'h001)); // see RULE7
    sum_up = {9'h000, raw_result} + {1'b0, shift_amount};
    diff_down = {9'h000, raw_result} - {1'b0, shift_amount};
    if (offset_trim[prox_pkg::PROX_SIGN_BIT]) begin
      // Sign one raises the result, clamped at full scale.
      corrected_result = (sum_up[24:16] != 9'h000) ? prox_pkg::PROX_RESULT_MAX
                         : sum_up[15:0]; // see RULE6 see RULE9
    end else begin
      // Sign zero lowers the result, clamped at zero.
      corrected_result = diff_down[24] ? 16'h0000 : diff_down[15:0]; // see RULE6 see RULE9
    end
  end
endmodule : prox_offset_calc
`default_nettype wire

// [prox_regs.sv]
// Proximity result and offset register bank.
// Assumes the serial interface presents byte reads and writes on ref_clk,
// and the measurement engine pulses sample_valid with each new result.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: Result is 16 bits, low byte at lower address, high byte next.
// RULE2: Reading low byte latches upper eight bits; high read returns latch.
// RULE3: Latched high byte stays consistent despite new conversions between reads.
// RULE4: Host should read both bytes in one auto-increment transaction; prox_host rd2 issues two separate single-byte reads.
// RULE5: Offset register is eight bits, sign-magnitude, bit seven the sign.
// RULE6: Sign zero shifts result down; sign one shifts it up.
// RULE7: Low seven bits size the shift, scaled by gain, drive, pulses.
// RULE8: Host should average several results to reduce noise.
// RULE9: Corrected result clamps to zero and full scale, never wraps.
module prox_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_rd_stb,
  input wire logic reg_wr_stb,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [15:0] raw_result,
  input wire logic sample_valid,
  input wire logic [1:0] proximity_gain_select,
  input wire logic [1:0] led_drive_strength,
  input wire logic [7:0] proximity_pulse_count,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic [7:0] offset_trim_out
);
  logic [15:0] result_q;
  logic [15:0] result_d;
  logic [7:0] shadow_q;
  logic [7:0] shadow_d;
  logic [7:0] offset_q;
  logic [7:0] offset_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [15:0] corrected;

  prox_offset_calc u_calc (
    .raw_result(raw_result),
    .offset_trim(offset_q),
    .proximity_gain_select(proximity_gain_select),
    .led_drive_strength(led_drive_strength),
    .proximity_pulse_count(proximity_pulse_count),
    .corrected_result(corrected)
  );

  always_comb begin
    result_d = result_q;
    shadow_d = shadow_q;
    offset_d = offset_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    // Live result follows each completed conversion.
    if (sample_valid) begin
      result_d = corrected;
    end
    if (reg_wr_stb && reg_addr == prox_pkg::PROX_OFFSET_ADDR) begin
      offset_d = reg_wdata; // see RULE5
    end
    if (reg_rd_stb) begin
      rvalid_d = 1'b1;
      unique case (reg_addr)
        prox_pkg::PROX_LOW_ADDR: begin
          rdata_d = result_q[7:0]; // see RULE1
          shadow_d = result_q[15:8]; // see RULE2
        end
        prox_pkg::PROX_HIGH_ADDR: begin
          // Shadow is only reloaded by a low read, not by new samples.
          rdata_d = shadow_q; // see RULE2 see RULE3
        end
        prox_pkg::PROX_OFFSET_ADDR: begin
          rdata_d = offset_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_q <= prox_pkg::PROX_RESULT_RESET;
      shadow_q <= 8'h00;
      offset_q <= prox_pkg::PROX_OFFSET_RESET;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      result_q <= result_d;
      shadow_q <= shadow_d;
      offset_q <= offset_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign offset_trim_out = offset_q;
endmodule : prox_regs
`default_nettype wire

// [prox_chk_checker.sv]
// Checker on the register bank ports.
// Assumes it is bound onto prox_regs.
`timescale 1ns/1ps
`default_nettype none
module prox_chk (input wire logic ref_clk, input wire logic rst, input wire logic reg_rd_stb,
  input wire logic reg_wr_stb, input wire logic [7:0] reg_addr, input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata, input wire logic reg_rvalid,
  input wire logic [7:0] offset_trim_out, input wire logic sample_valid);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rv; reg_rd_stb |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_nrv; !reg_rd_stb |=> !reg_rvalid; endproperty
  a_nrv: assert property (p_nrv) else $error("stray read valid");
  property p_wr; reg_wr_stb && reg_addr == 8'h1E |=> offset_trim_out == $past(reg_wdata); endproperty
  a_wr: assert property (p_wr) else $error("offset not written");
  property p_keep; !(reg_wr_stb && reg_addr == 8'h1E) |=> $stable(offset_trim_out); endproperty
  a_keep: assert property (p_keep) else $error("offset changed");
  property p_ord; reg_rd_stb && !reg_wr_stb && reg_addr == 8'h1E |=> reg_rdata == offset_trim_out;
  endproperty
  a_ord: assert property (p_ord) else $error("offset readback wrong");
  property p_hold; !reg_rd_stb |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  c_pair: cover property (reg_rd_stb && reg_addr == 8'h18 ##[1:8] reg_rd_stb && reg_addr == 8'h19);
  c_wr: cover property (reg_wr_stb && reg_addr == 8'h1E);
  c_mid: cover property (reg_rd_stb && reg_addr == 8'h18 ##[1:8] sample_valid);
endmodule : prox_chk
bind prox_regs prox_chk u_chk (.*);
`default_nettype wire

// [prox_host.sv]
// Host model issuing byte reads and writes.
// Assumes the register bank shares ref_clk.
`timescale 1ns/1ps
`default_nettype none
module prox_host (input wire logic ref_clk, output logic rd, output logic wr,
  output logic [7:0] addr, output logic [7:0] wd, input wire logic [7:0] rdata);
  initial {rd, wr, addr, wd} = 18'h00000;
  task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    {rd, wr, addr, wd} <= {!w, w, a, d};
    @(posedge ref_clk);
    {rd, wr} <= 2'h0;
    @(negedge ref_clk);
    q = rdata;
  endtask : xf
  task automatic rd2(output logic [7:0] lo, output logic [7:0] hi);
    xf(1'b0, 8'h18, 8'h00, lo);
    xf(1'b0, 8'h19, 8'h00, hi);
  endtask : rd2
  // Averages four result reads so a single noisy sample does not dominate.
  task automatic avg4(output logic [15:0] m);
    logic [7:0] lo;
    logic [7:0] hi;
    logic [17:0] acc;
    acc = 18'h00000;
    repeat (4) begin
      rd2(lo, hi);
      acc = acc + {2'h0, hi, lo};
    end
    m = acc[17:2];
  endtask : avg4
endmodule : prox_host
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the register bank.
// Assumes prox_regs, prox_host and the checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0, rst = 1'b1, sv = 1'b0, rd, wr, rv;
  logic [15:0] raw = 16'h0000, r, e;
  logic [7:0] addr, wd, rdata, off_q, o, lo, hi, q, pc = 8'h00;
  logic [1:0] g = 2'h0, dr = 2'h0;
  int error_cnt = 0, total_checks = 0;
  initial forever #10 ref_clk = ~ref_clk;
  prox_host u_host (.ref_clk(ref_clk), .rd(rd), .wr(wr), .addr(addr), .wd(wd), .rdata(rdata));
  prox_regs u_dut (.ref_clk(ref_clk), .rst(rst), .reg_rd_stb(rd), .reg_wr_stb(wr),
    .reg_addr(addr), .reg_wdata(wd), .raw_result(raw), .sample_valid(sv),
    .proximity_gain_select(g), .led_drive_strength(dr), .proximity_pulse_count(pc),
    .reg_rdata(rdata), .reg_rvalid(rv), .offset_trim_out(off_q));
  function automatic logic [15:0] exp_f(logic [15:0] x, logic [7:0] f);
    int s = int'(f[6:0]) * ((g == 0) ? 1 : (g == 1) ? 2 : (g == 2) ? 4 : 7);
    int v;
    s = s * (4 - int'(dr)) * (int'(pc) + 1);
    v = f[7] ? int'(x) + s : int'(x) - s;
    return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hFFFF : 16'(v);
  endfunction : exp_f
  task automatic chk(input logic [7:0] got, input logic [7:0] ex);
    total_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, ex);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic smp(input logic [15:0] x);
    @(posedge ref_clk);
    {raw, sv} <= {x, 1'b1};
    @(posedge ref_clk);
    sv <= 1'b0;
  endtask : smp
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    close_out;
  end
  initial begin
    void'($urandom(73));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      o = (i == 0) ? 8'h7F : (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : 8'($urandom);
      r = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
      @(posedge ref_clk);
      {g, dr, pc} <= {2'($urandom), 2'($urandom), 8'($urandom % 8)};
      u_host.xf(1'b1, 8'h1E, o, q);
      u_host.xf(1'b0, 8'h1E, 8'h00, q);
      chk(q, o);
      chk(off_q, o);
      smp(r);
      u_host.rd2(lo, hi);
      e = exp_f(r, o);
      chk(lo, e[7:0]);
      chk(hi, e[15:8]);
      u_host.xf(1'b0, 8'h18, 8'h00, q);
      smp(~r);
      u_host.xf(1'b0, 8'h19, 8'h00, q);
      chk(q, e[15:8]);
    end
    smp(16'h1234);
    e = exp_f(16'h1234, o);
    u_host.avg4(r);
    chk(r[7:0], e[7:0]);
    chk(r[15:8], e[15:8]);
    u_host.xf(1'b0, 8'h20, 8'h00, q);
    chk(q, 8'h00);
    close_out;
  end
endmodule : tb_top
`default_nettype wire
